// ### pkg/msel_pkg.sv
// constants and types shared by the memory strobe and select logic
package msel_pkg;
  localparam int unsigned ADDR_W         = 19;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned STROBE_CLKS    = 2;
  localparam int unsigned CNT_W          = 4;
  localparam logic        STROBE_IDLE    = 1'b1;
  localparam logic        ADDR0_RST      = 1'b1;
  localparam logic [1:0]  BE_WORD        = 2'h3;
  localparam logic [15:0] DATA_RST       = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STROBE,
    ST_GAP
  } msel_state_e;
endpackage : msel_pkg

// ### pkg/msel_cyc_if.sv
// one memory bus cycle as seen by the strobe decoder
interface msel_cyc_if;
  import msel_pkg::*;
  logic              act;
  logic              wr;
  logic              wide;
  logic              five;
  logic              lo;
  logic              hi;
  logic              ramHit;
  logic              nvHit;
  logic              addr0;
  logic [DATA_W-1:0] wdata;

  modport src (output act, wr, wide, five, lo, hi, ramHit, nvHit, addr0, wdata);
  modport dec (input act, wr, wide, five, lo, hi, ramHit, nvHit, addr0, wdata);
endinterface : msel_cyc_if

// ### hw/msel_strobe_dec.sv
// registered strobe, select and data pin drive for one bus cycle
module msel_strobe_dec
  import msel_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  msel_cyc_if.dec                          cyc,
  output logic                             memOutputEnable_n,
  output logic                             lowerByteEnable_n,
  output logic                             lowByteWriteStrobe_n,
  output logic                             ramSelect_n,
  output logic                             nonvolatileSelect_n,
  output logic                             memAddrBit0,
  output logic [msel_pkg::DATA_W-1:0]      memDataOut,
  output logic [msel_pkg::DATA_W-1:0]      memDataOe_n
);
  import msel_pkg::*;

  // the high-byte strobe is on the shared address-bit-0 pin in 4-wire mode; 5-wire writes both bytes on the low strobe
  wire       fourWide = cyc.wide & ~cyc.five;
  wire       rdCyc    = cyc.act & ~cyc.wr;
  wire       wrCyc    = cyc.act & cyc.wr;
  wire       oeD      = ~rdCyc;
  wire       lbeD     = ~(cyc.act & cyc.wide & cyc.five & cyc.lo);
  wire       lweD     = ~(wrCyc & (~cyc.wide | cyc.five | cyc.lo));
  wire       hweD     = ~(wrCyc & fourWide & cyc.hi);
  wire       ramD     = ~(cyc.act & cyc.ramHit);
  wire       nvD      = ~(cyc.act & cyc.nvHit & ~cyc.ramHit);
  // bit 0 rests high between cycles: on 4-wire x16 parts it is a write strobe
  wire       a0D      = cyc.act ? (fourWide ? hweD : cyc.addr0) : ADDR0_RST;
  wire [1:0] laneDrv  = {wrCyc & cyc.wide & cyc.hi, wrCyc & (cyc.lo | ~cyc.wide)};

  always_ff @(posedge clk) begin
    if (rst) begin
      memOutputEnable_n    <= STROBE_IDLE;
      lowerByteEnable_n    <= STROBE_IDLE;
      lowByteWriteStrobe_n <= STROBE_IDLE;
      ramSelect_n          <= STROBE_IDLE;
      nonvolatileSelect_n  <= STROBE_IDLE;
      memAddrBit0          <= ADDR0_RST;
    end else begin
      memOutputEnable_n    <= oeD;
      lowerByteEnable_n    <= lbeD;
      lowByteWriteStrobe_n <= lweD;
      ramSelect_n          <= ramD;
      nonvolatileSelect_n  <= nvD;
      memAddrBit0          <= a0D;
    end
  end

  // each data line is its own pin with its own enable
  for (genvar b = 0; b < DATA_W; b++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        memDataOut[b]  <= 1'b0;
        memDataOe_n[b] <= 1'b1;
      end else begin
        memDataOut[b]  <= cyc.wdata[b];
        memDataOe_n[b] <= ~laneDrv[b / BYTE_W];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sel_exclusive: assert property (!(!ramSelect_n && !nonvolatileSelect_n))
    else $error("both selects low");
  a_bit0_idle: assert property (!cyc.act |=> memAddrBit0)
    else $error("bit0 strobe low while idle");
  a_idle_quiet: assert property (!cyc.act |=> memOutputEnable_n && lowByteWriteStrobe_n
      && lowerByteEnable_n && ramSelect_n && nonvolatileSelect_n && (&memDataOe_n))
    else $error("strobe active while idle");
  a_read_oe: assert property (rdCyc |=> !memOutputEnable_n && lowByteWriteStrobe_n)
    else $error("read without output enable");
  a_write_no_oe: assert property (!memOutputEnable_n |-> lowByteWriteStrobe_n)
    else $error("output enable on write");
  a_lbe_five: assert property (cyc.act && cyc.wide && cyc.five && cyc.lo |=> !lowerByteEnable_n)
    else $error("lower byte enable missing");
  a_x8_write: assert property (wrCyc && !cyc.wide |=> !lowByteWriteStrobe_n
      && memDataOe_n == 16'hFF00)
    else $error("x8 write strobe or lanes wrong");
  a_five_write: assert property (wrCyc && cyc.wide && cyc.five |=> !lowByteWriteStrobe_n)
    else $error("5-wire write strobe missing");
  a_four_low: assert property (wrCyc && fourWide |=> lowByteWriteStrobe_n != $past(cyc.lo))
    else $error("4-wire low strobe wrong");
  a_four_high: assert property (wrCyc && fourWide && cyc.hi |=> !memAddrBit0)
    else $error("4-wire high strobe missing");
  a_ram_sel: assert property (cyc.act && cyc.ramHit |=> !ramSelect_n)
    else $error("ram select missing");
  a_nv_sel: assert property (cyc.act && cyc.nvHit && !cyc.ramHit |=> !nonvolatileSelect_n)
    else $error("nv select missing");
endmodule : msel_strobe_dec

// ### hw/msel_top.sv
// memory bus cycle sequencer with strobe and chip-select generation
module msel_top
  import msel_pkg::*;
#(
  parameter int unsigned STROBE_LEN = msel_pkg::STROBE_CLKS
)
(
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        cfgWide,
  input  wire logic                        cfgFiveWire,
  input  wire logic [msel_pkg::ADDR_W-1:1] ramBase,
  input  wire logic [msel_pkg::ADDR_W-1:1] ramLimit,
  input  wire logic [msel_pkg::ADDR_W-1:1] nvBase,
  input  wire logic [msel_pkg::ADDR_W-1:1] nvLimit,
  input  wire logic                        reqValid,
  output logic                             reqReady,
  input  wire logic                        reqWrite,
  input  wire logic [msel_pkg::ADDR_W-1:1] reqAddr,
  input  wire logic [1:0]                  reqByteEn,
  input  wire logic [msel_pkg::DATA_W-1:0] reqWdata,
  output logic                             rspValid,
  output logic [msel_pkg::DATA_W-1:0]      rspRdata,
  output logic [msel_pkg::ADDR_W-1:1]      memAddr,
  output logic                             memAddrBit0,
  output logic                             memOutputEnable_n,
  output logic                             lowerByteEnable_n,
  output logic                             lowByteWriteStrobe_n,
  output logic                             ramSelect_n,
  output logic                             nonvolatileSelect_n,
  input  wire logic [msel_pkg::DATA_W-1:0] memDataIn,
  output logic [msel_pkg::DATA_W-1:0]      memDataOut,
  output logic [msel_pkg::DATA_W-1:0]      memDataOe_n
);
  import msel_pkg::*;

  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(STROBE_LEN);

  msel_state_e       state_q;
  msel_state_e       state_d;
  logic [CNT_W-1:0]  cnt_q;
  logic              wr_q;
  logic              wide_q;
  logic              five_q;
  logic              ramHit_q;
  logic              nvHit_q;
  logic              odd_q;
  logic              second_q;
  logic              rsp_q;
  logic [1:0]        be_q;
  logic [ADDR_W-1:1] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] rdata_q;

  msel_cyc_if cyc ();

  // ram wins an overlap so the two selects can never meet
  wire inRam     = (reqAddr >= ramBase) && (reqAddr <= ramLimit);
  wire inNv      = (reqAddr >= nvBase) && (reqAddr <= nvLimit) && !inRam;
  wire startReq  = (state_q == ST_IDLE) && reqValid;
  wire x8Word    = !cfgWide && (reqByteEn == BE_WORD);
  wire strobeEnd = (state_q == ST_STROBE) && (cnt_q == CNT_W'(1));
  wire inGap     = (state_q == ST_GAP);
  wire lastGap   = inGap && !second_q;
  wire [BYTE_W-1:0] rdByte = memDataIn[BYTE_W-1:0];

  assign reqReady = (state_q == ST_IDLE);
  assign rspValid = rsp_q;
  assign rspRdata = rdata_q;
  assign memAddr  = addr_q;

  assign cyc.act    = (state_q == ST_STROBE);
  assign cyc.wr     = wr_q;
  assign cyc.wide   = wide_q;
  assign cyc.five   = five_q;
  assign cyc.lo     = wide_q ? be_q[0] : !odd_q;
  assign cyc.hi     = wide_q ? be_q[1] : odd_q;
  assign cyc.ramHit = ramHit_q;
  assign cyc.nvHit  = nvHit_q;
  assign cyc.addr0  = wide_q ? 1'b0 : odd_q;
  // an x8 part only sees the low lane, so the chosen byte is steered there
  assign cyc.wdata  = wide_q ? wdata_q : {wdata_q[15:8], odd_q ? wdata_q[15:8] : wdata_q[7:0]};

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   if (reqValid) state_d = ST_STROBE;
      ST_STROBE: if (cnt_q == CNT_W'(1)) state_d = ST_GAP;
      ST_GAP:    state_d = second_q ? ST_STROBE : ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      rsp_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      rsp_q   <= lastGap;
      if (startReq || (inGap && second_q)) begin
        cnt_q <= CNT_LOAD;
      end else if (state_q == ST_STROBE) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q     <= 1'b0;
      wide_q   <= 1'b0;
      five_q   <= 1'b0;
      ramHit_q <= 1'b0;
      nvHit_q  <= 1'b0;
      be_q     <= '0;
      addr_q   <= '0;
      wdata_q  <= DATA_RST;
    end else if (startReq) begin
      wr_q     <= reqWrite;
      wide_q   <= cfgWide;
      five_q   <= cfgFiveWire;
      ramHit_q <= inRam;
      nvHit_q  <= inNv;
      be_q     <= reqByteEn;
      addr_q   <= reqAddr;
      wdata_q  <= reqWdata;
    end
  end

  // x8 word: high byte goes out first, even byte follows after a gap
  always_ff @(posedge clk) begin
    if (rst) begin
      odd_q    <= 1'b0;
      second_q <= 1'b0;
    end else if (startReq) begin
      odd_q    <= x8Word ? 1'b1 : reqByteEn[1];
      second_q <= x8Word;
    end else if (inGap && second_q) begin
      odd_q    <= 1'b0;
      second_q <= 1'b0;
    end
  end

  // pins are still driven during the gap, so read data are sampled there
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= DATA_RST;
    end else if (inGap && !wr_q) begin
      if (wide_q) begin
        rdata_q <= memDataIn;
      end else if (odd_q) begin
        rdata_q[15:8] <= rdByte;
      end else begin
        rdata_q[7:0] <= rdByte;
      end
    end
  end

  msel_strobe_dec u_dec (
    .clk                  (clk),
    .rst                  (rst),
    .cyc                  (cyc),
    .memOutputEnable_n    (memOutputEnable_n),
    .lowerByteEnable_n    (lowerByteEnable_n),
    .lowByteWriteStrobe_n (lowByteWriteStrobe_n),
    .ramSelect_n          (ramSelect_n),
    .nonvolatileSelect_n  (nonvolatileSelect_n),
    .memAddrBit0          (memAddrBit0),
    .memDataOut           (memDataOut),
    .memDataOe_n          (memDataOe_n)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_word_odd_first: assert property (startReq && x8Word |=> odd_q && second_q && cyc.addr0)
    else $error("x8 word did not start on odd byte");
  a_even_follows: assert property (inGap && second_q |=> cyc.act && !odd_q && !cyc.addr0)
    else $error("even byte did not follow");
  a_gap_quiet: assert property (strobeEnd |=> ##1 memOutputEnable_n && lowByteWriteStrobe_n)
    else $error("strobes not released after cycle");
  a_select_split: assert property (startReq |=> !(ramHit_q && nvHit_q))
    else $error("both areas hit");
  a_resp_after: assert property (lastGap |=> rspValid ##1 !rspValid)
    else $error("response pulse wrong");

  // datapath steering, capture, and a request frozen while busy
  a_cnt_load: assert property (startReq |=> cyc.act && cnt_q == CNT_LOAD)
    else $error("strobe count not loaded");
  a_busy_hold: assert property (!reqReady |=> $stable(addr_q) && $stable(wr_q))
    else $error("request changed while busy");
  a_rsp_idle: assert property (rspValid |-> reqReady)
    else $error("response while busy");
  a_x8_odd_data: assert property (startReq && x8Word |=> cyc.wdata[BYTE_W-1:0] == wdata_q[DATA_W-1:BYTE_W])
    else $error("odd byte not on low lane");
  a_x8_even_data: assert property (inGap && second_q |=> cyc.wdata[BYTE_W-1:0] == wdata_q[BYTE_W-1:0])
    else $error("even byte not on low lane");
  a_read_capture: assert property (lastGap && !wr_q && wide_q |=> rspRdata == $past(memDataIn))
    else $error("x16 read data not captured");
  a_x8_read_lane: assert property (inGap && !wr_q && !wide_q && !odd_q |=> rspRdata[BYTE_W-1:0] == $past(rdByte))
    else $error("x8 even byte not captured");

  c_x8_word_wr: cover property (startReq && x8Word && reqWrite);
  c_x16_four_hi: cover property (startReq && cfgWide && !cfgFiveWire && reqByteEn == 2'h2 && reqWrite);
  c_x16_read: cover property (startReq && cfgWide && !reqWrite ##[1:20] rspValid);
  c_nv_cycle: cover property (!nonvolatileSelect_n);
endmodule : msel_top

// ### sim/msel_mem_model.sv
// far-side memory part: byte store on the strobes, pulled data lines when released
module msel_mem_model
  import msel_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        wide,
  input  wire logic [msel_pkg::ADDR_W-1:1] addr,
  input  wire logic                        addr0,
  input  wire logic                        oe_n,
  input  wire logic                        we_n,
  input  wire logic                        ramSel_n,
  input  wire logic                        nvSel_n,
  input  wire logic [msel_pkg::DATA_W-1:0] dout,
  input  wire logic [msel_pkg::DATA_W-1:0] doe_n,
  output logic      [msel_pkg::DATA_W-1:0] din
);
  timeunit 1ns;
  timeprecision 1ns;
  import msel_pkg::*;
  // resistor level per line once nobody drives it
  localparam logic [15:0] PULL = 16'hCE00;
  logic [7:0] mem [int];
  wire        sel = !ramSel_n || !nvSel_n;

  function automatic logic [7:0] rd(input int k);
    return mem.exists(k) ? mem[k] : 8'hA5;
  endfunction : rd

  // each lane stored as one whole byte, address bit 0 lowest in the key
  always @(posedge clk) begin
    if (sel && !we_n && doe_n[0] === 1'b0)
      mem[int'({addr, wide ? 1'b0 : addr0})] = dout[7:0];
    // high lane: low strobe in 5-wire style, bit0 strobe in 4-wire style
    if (sel && wide && (!we_n || !addr0) && doe_n[8] === 1'b0)
      mem[int'({addr, 1'b1})] = dout[15:8];
  end

  // answer only while selected and output enabled, else lines float to pulls
  always @(negedge clk) begin
    if (!sel || oe_n)
      din <= PULL;
    else if (wide)
      din <= {rd(int'({addr, 1'b1})), rd(int'({addr, 1'b0}))};
    else
      din <= {PULL[15:8], rd(int'({addr, addr0}))};
  end
endmodule : msel_mem_model

// ### sim/tb_memory_bus_strobe_select.sv
// self-checking bench for the memory strobe and select sequencer
module tb_memory_bus_strobe_select
  import msel_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SLEN = 2;
  // seen flags, low seen on: oe, lower enable, low strobe, ram, nv, bit0 while selected
  typedef struct packed {
    logic        w, f, wr;
    logic [17:0] a;
    logic [1:0]  be;
    logic [15:0] d;
    logic [5:0]  seen;
  } msel_row_s;
  localparam msel_row_s ROWS [10] = '{
    '{1'b1, 1'b1, 1'b1, 18'h00010, 2'h1, 16'h1234, 6'h1D},
    '{1'b1, 1'b1, 1'b1, 18'h00010, 2'h2, 16'hAB00, 6'h0D},
    '{1'b1, 1'b1, 1'b0, 18'h00010, 2'h3, 16'hAB34, 6'h35},
    '{1'b1, 1'b0, 1'b1, 18'h00011, 2'h2, 16'h5600, 6'h05},
    '{1'b1, 1'b0, 1'b1, 18'h00011, 2'h1, 16'h0078, 6'h0C},
    '{1'b1, 1'b0, 1'b0, 18'h00011, 2'h3, 16'h5678, 6'h24},
    '{1'b0, 1'b0, 1'b1, 18'h10005, 2'h3, 16'h9ABC, 6'h0B},
    '{1'b0, 1'b0, 1'b0, 18'h10005, 2'h3, 16'h9ABC, 6'h23},
    '{1'b0, 1'b0, 1'b1, 18'h20000, 2'h1, 16'h00EE, 6'h08},
    '{1'b0, 1'b0, 1'b0, 18'h10005, 2'h2, 16'h9ABC, 6'h22}};
  logic        clk = 1'b0, rst = 1'b1, cfgWide = 1'b1, cfgFiveWire = 1'b1;
  logic        reqValid = 1'b0, reqWrite = 1'b0, reqReady, rspValid, memAddrBit0;
  logic [17:0] reqAddr = '0, memAddr;
  logic [1:0]  reqByteEn = '0;
  logic [15:0] reqWdata = '0, rspRdata, memDataIn, memDataOut, memDataOe_n;
  logic        memOutputEnable_n, lowerByteEnable_n, lowByteWriteStrobe_n, ramSelect_n, nonvolatileSelect_n;
  int          nErrors = 0, nCompared = 0;

  always #50 clk = ~clk;

  msel_top #(.STROBE_LEN(SLEN)) uut (.clk(clk), .rst(rst), .cfgWide(cfgWide), .cfgFiveWire(cfgFiveWire),
    .ramBase(18'h00000), .ramLimit(18'h0FFFF), .nvBase(18'h10000), .nvLimit(18'h1FFFF),
    .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqByteEn(reqByteEn), .reqWdata(reqWdata), .rspValid(rspValid), .rspRdata(rspRdata),
    .memAddr(memAddr), .memAddrBit0(memAddrBit0), .memOutputEnable_n(memOutputEnable_n),
    .lowerByteEnable_n(lowerByteEnable_n), .lowByteWriteStrobe_n(lowByteWriteStrobe_n),
    .ramSelect_n(ramSelect_n), .nonvolatileSelect_n(nonvolatileSelect_n), .memDataIn(memDataIn),
    .memDataOut(memDataOut), .memDataOe_n(memDataOe_n));

  msel_mem_model mem_u (.clk(clk), .wide(cfgWide), .addr(memAddr), .addr0(memAddrBit0),
    .oe_n(memOutputEnable_n), .we_n(lowByteWriteStrobe_n), .ramSel_n(ramSelect_n), .nvSel_n(nonvolatileSelect_n),
    .dout(memDataOut), .doe_n(memDataOe_n), .din(memDataIn));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic finishTest();
    $display("errors %0d of %0d compared", nErrors, nCompared);
    if (nErrors == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finishTest

  task automatic idleChk();
    check({memOutputEnable_n, lowerByteEnable_n, lowByteWriteStrobe_n, ramSelect_n, nonvolatileSelect_n}, 5'h1F);
    check({memDataOe_n, memDataOut}, 32'hFFFF0000);
    check({memAddrBit0, reqReady, rspValid}, 3'b110);
  endtask : idleChk

  // one request; clocks counted to the answer, strobes gathered on the way
  task automatic doRow(input msel_row_s r);
    int         n;
    logic [5:0] s;
    @(negedge clk);
    {cfgWide, cfgFiveWire, reqWrite, reqAddr, reqByteEn, reqWdata} = {r.w, r.f, r.wr, r.a, r.be, r.d};
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    n = 1;
    s = '0;
    while (rspValid !== 1'b1 && n < 40) begin
      s |= ~{memOutputEnable_n, lowerByteEnable_n, lowByteWriteStrobe_n, ramSelect_n, nonvolatileSelect_n,
             memAddrBit0 | (ramSelect_n & nonvolatileSelect_n)};
      check(ramSelect_n | nonvolatileSelect_n, 1'b1);
      @(negedge clk);
      n++;
    end
    check(n, (r.w || r.be != 2'h3) ? SLEN + 2 : 2 * SLEN + 3);
    check(s, r.seen);
    check({memOutputEnable_n, lowByteWriteStrobe_n, ramSelect_n, nonvolatileSelect_n}, 4'hF);
    check(memAddr, r.a);
    if (!r.wr)
      check(rspRdata, r.d);
  endtask : doRow

  initial begin
    #100_000;
    nErrors++;
    finishTest();
  end

  initial begin
    repeat (5) @(negedge clk);
    idleChk();
    rst = 1'b0;
    @(negedge clk);
    idleChk();
    foreach (ROWS[i])
      doRow(ROWS[i]);
    // x8 word: odd byte must go out first with bit0 high, then the even byte
    fork
      doRow('{1'b0, 1'b0, 1'b1, 18'h10006, 2'h3, 16'hC3D2, 6'h0B});
      begin
        for (int k = 0; k < 20 && lowByteWriteStrobe_n !== 1'b0; k++)
          @(negedge clk);
        check({lowByteWriteStrobe_n, memAddrBit0, memDataOut[7:0], memDataOe_n[7:0]}, {2'b01, 8'hC3, 8'h00});
        for (int k = 0; k < 20 && lowByteWriteStrobe_n !== 1'b1; k++)
          @(negedge clk);
        for (int k = 0; k < 20 && lowByteWriteStrobe_n !== 1'b0; k++)
          @(negedge clk);
        check({lowByteWriteStrobe_n, memAddrBit0, memDataOut[7:0]}, {2'b00, 8'hD2});
      end
    join
    doRow('{1'b0, 1'b0, 1'b0, 18'h10006, 2'h3, 16'hC3D2, 6'h23});
    // reset dropped in mid-strobe must quiet every pin at once
    @(negedge clk);
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    idleChk();
    rst = 1'b0;
    // pins stay quiet after release, then the cut word reads back whole
    @(negedge clk);
    idleChk();
    doRow('{1'b0, 1'b0, 1'b0, 18'h10006, 2'h3, 16'hC3D2, 6'h23});
    finishTest();
  end
endmodule : tb_memory_bus_strobe_select
